/* hw/dts_switchover.sv */
// Switchover controller between normal and dynamic overcurrent settings, with APB registers.
`timescale 1ns/100ps
// Summary of operation
// - Aux contact source: breaker open input means the equipment is de-energized.
// - Zero current source: current below threshold means de-energized.
// - De-energization starts the wait timer; dynamic settings only after it expires.
// - Reclose source: dynamic settings while the reclose ready signal is high.
// - The activate input releases dynamic settings under any source, unless blocked or switched off.
// - Re-energization starts the hold timer; on expiry normal settings return.
// - Hold is cut short when current stays below normal pickups for fast time.
// - Fast reset starts on the OR of all element dropout conditions.
// - Infinite fast time or stop-time block disables and clears fast reset timing.
// - A pickup during hold keeps dynamic settings until that pickup drops out.
// - Dropping the activate or reclose cause restores normal settings at once.
// - The block input clears all timers and restores normal settings immediately.
// - Block during a fault with dynamic active restarts all element timers.
// - Power-up with breaker open runs the wait timer under normal settings.
// - Works alongside, and independent of, the four setting groups.
// - Usable only if enabled at build time, plus a runtime on/off bit.
module dts_switchover #(
   parameter int unsigned TICK_DIV = dts_pkg::TICK_CYCLES,
   parameter bit FEATURE_EN = 1'b1,
   parameter int unsigned N_ELEM = 8
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire dts_pkg::dts_pins_t pins_in,
   input wire logic reclose_ready_in,
   input wire logic current_below_min_in,
   input wire logic current_above_closed_in,
   input wire logic [N_ELEM-1:0] dropout_cond_in,
   input wire logic pickup_any_in,
   output logic dynamic_select_out,
   output logic elem_timer_restart_out
);
   import dts_pkg::*;

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   dts_pins_t pin;
   dts_cfg_t cfg_q;
   dts_state_t state_q;
   dts_state_t state_d;
   logic [31:0] div_q;
   logic tick;
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] tmr_d;
   logic [TMR_W-1:0] fast_q;
   logic [TMR_W-1:0] fast_d;
   logic dyn_q;
   logic block_seen_q;
   logic restart_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Binary inputs come from pins, so they are synchronised before use.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end else begin
         pin_s1_q <= pins_in;
         pin_s2_q <= pin_s1_q;
      end
   end
   assign pin = dts_pins_t'(pin_s2_q);

   // Common time base for all three timers.
   assign tick = (div_q == 32'(TICK_DIV - 1));
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 32'h0;
      end else begin
         div_q <= tick ? 32'h0 : div_q + 32'h1;
      end
   end

   wire active = FEATURE_EN && cfg_q.on;
   wire blocked = pin.block_dynamic;
   wire src_aux = (cfg_q.src == SRC_AUX_CONTACT);
   wire src_zero = (cfg_q.src == SRC_ZERO_CURRENT);
   wire deenergized = (src_aux && !pin.breaker_closed)
                    || (src_zero && current_below_min_in);
   wire reenergized = (src_aux && pin.breaker_closed)
                    || (src_zero && current_above_closed_in);
   wire fast_off = cfg_q.fast_inf || pin.block_stop_time;
   wire fast_start = |dropout_cond_in;
   wire tmr_done = (tmr_q >= ((state_q == ST_WAIT) ? cfg_q.wait_time : cfg_q.hold_time));
   wire fast_done = !fast_off && (fast_q >= cfg_q.fast_time);
   wire fast_run = (state_q == ST_HOLD) && !fast_off && fast_start;
   // The forced causes bypass the state machine, so losing them drops dynamic at once.
   wire forced = pin.activate_dynamic
               || ((cfg_q.src == SRC_RECLOSE_READY) && reclose_ready_in);
   wire state_dyn = (state_q == ST_DYN_OPEN) || (state_q == ST_HOLD) || (state_q == ST_PICKUP);
   wire dyn_d = active && !blocked && (forced || state_dyn);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_ENERGIZED: begin
            if (deenergized) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!deenergized) begin
               state_d = ST_ENERGIZED;
            end else if (tmr_done) begin
               state_d = ST_DYN_OPEN;
            end
         end
         ST_DYN_OPEN: begin
            if (reenergized) begin
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (tmr_done || fast_done) begin
               state_d = pickup_any_in ? ST_PICKUP : ST_ENERGIZED;
            end
         end
         ST_PICKUP: begin
            if (!pickup_any_in) begin
               state_d = ST_ENERGIZED;
            end
         end
         default: begin
            state_d = ST_ENERGIZED;
         end
      endcase
      // Block and a disabled function override everything, also the reclose source.
      if (!active || blocked || (cfg_q.src == SRC_RECLOSE_READY)) begin
         state_d = ST_ENERGIZED;
      end
   end

   always_comb begin
      tmr_d = tmr_q;
      if (state_d != state_q) begin
         tmr_d = '0;
      end else if (tick && ((state_q == ST_WAIT) || (state_q == ST_HOLD)) && !tmr_done) begin
         tmr_d = tmr_q + 1'b1;
      end
      fast_d = '0;
      if (fast_run && (state_d == ST_HOLD)) begin
         fast_d = (tick && !fast_done) ? fast_q + 1'b1 : fast_q;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_ENERGIZED;
         tmr_q <= '0;
         fast_q <= '0;
         dyn_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         fast_q <= fast_d;
         dyn_q <= dyn_d;
      end
   end

   // A fresh block during a fault under dynamic settings restarts the element timers.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         block_seen_q <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         block_seen_q <= blocked;
         restart_q <= blocked && !block_seen_q && dyn_q && pickup_any_in;
      end
   end

   // The select and timer restart outputs are the only coupling to the elements; group selection is untouched.
   assign dynamic_select_out = dyn_q;
   assign elem_timer_restart_out = restart_q;

   // APB slave: one wait state, answer registered.
   wire acc = psel_in && penable_in && !pready_q;
   wire commit = psel_in && penable_in && pready_q;
   wire hit_ctrl = (paddr_in == OFS_CTRL);
   wire hit_wait = (paddr_in == OFS_WAIT);
   wire hit_hold = (paddr_in == OFS_HOLD);
   wire hit_fast = (paddr_in == OFS_FAST);
   wire hit_stat = (paddr_in == OFS_STATUS);
   wire mapped = hit_ctrl || hit_wait || hit_hold || hit_fast || hit_stat;
   wire wr = commit && pwrite_in && !pslverr_q;
   wire [31:0] ctrl_rd = {28'h0, cfg_q.fast_inf, cfg_q.src, cfg_q.on};
   wire [31:0] stat_rd = {26'h0, pin.breaker_closed, fast_run, state_q, dyn_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_rd
                      : hit_wait ? {16'h0, cfg_q.wait_time}
                      : hit_hold ? {16'h0, cfg_q.hold_time}
                      : hit_fast ? {16'h0, cfg_q.fast_time}
                      : hit_stat ? stat_rd : 32'h0;
   wire [1:0] src_wr = pwdata_in[CTRL_SRC_LSB +: 2];

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
         prdata_q <= (acc && !pwrite_in) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '{fast_inf: 1'b0, src: SRC_ZERO_CURRENT, on: 1'b0,
                    wait_time: WAIT_RST, hold_time: HOLD_RST, fast_time: FAST_RST};
      end else if (wr) begin
         if (hit_ctrl) begin
            cfg_q.on <= pwdata_in[CTRL_ON_BIT];
            cfg_q.fast_inf <= pwdata_in[CTRL_FAST_INF_BIT];
            // An unused source code is ignored so the selection stays legal.
            if (src_wr <= 2'h2) begin
               cfg_q.src <= dts_src_t'(src_wr);
            end
         end
         if (hit_wait) begin
            cfg_q.wait_time <= pwdata_in[TMR_W-1:0];
         end
         if (hit_hold) begin
            cfg_q.hold_time <= pwdata_in[TMR_W-1:0];
         end
         if (hit_fast) begin
            cfg_q.fast_time <= pwdata_in[TMR_W-1:0];
         end
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
endmodule : dts_switchover

/* hw/dts_pkg.sv */
// Shared constants, register map and types of the dynamic threshold switchover block.
package dts_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam longint unsigned TICK_PERIOD_NS = 64'h3B9ACA00;
   localparam int unsigned TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
   localparam int unsigned TMR_W = 16;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAIT = 8'h04;
   localparam logic [7:0] OFS_HOLD = 8'h08;
   localparam logic [7:0] OFS_FAST = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int unsigned CTRL_ON_BIT = 0;
   localparam int unsigned CTRL_SRC_LSB = 1;
   localparam int unsigned CTRL_FAST_INF_BIT = 3;
   localparam logic [TMR_W-1:0] WAIT_RST = 16'h0E10;
   localparam logic [TMR_W-1:0] HOLD_RST = 16'h0E10;
   localparam logic [TMR_W-1:0] FAST_RST = 16'h0258;
   localparam int unsigned ST_DYN_BIT = 0;
   localparam int unsigned ST_STATE_LSB = 1;
   localparam int unsigned ST_FAST_BIT = 4;
   localparam int unsigned ST_BRK_BIT = 5;
   typedef enum logic [1:0] {
      SRC_ZERO_CURRENT,
      SRC_AUX_CONTACT,
      SRC_RECLOSE_READY
   } dts_src_t;
   typedef enum logic [2:0] {
      ST_ENERGIZED,
      ST_WAIT,
      ST_DYN_OPEN,
      ST_HOLD,
      ST_PICKUP
   } dts_state_t;
   typedef struct packed {
      logic breaker_closed;
      logic activate_dynamic;
      logic block_dynamic;
      logic block_stop_time;
   } dts_pins_t;
   typedef struct packed {
      logic fast_inf;
      dts_src_t src;
      logic on;
      logic [TMR_W-1:0] wait_time;
      logic [TMR_W-1:0] hold_time;
      logic [TMR_W-1:0] fast_time;
   } dts_cfg_t;
endpackage : dts_pkg

/* testbench/dts_checker.sv */
// Port-level assertions for the switchover block.
`timescale 1ns/100ps
module dts_checker (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire dts_pkg::dts_pins_t pins_in,
   input wire logic pickup_any_in,
   input wire logic dynamic_select_out,
   input wire logic elem_timer_restart_out
);
   import dts_pkg::*;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   a_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("ready not one cycle after access");
   a_err_map: assert property (pready_out && paddr_in[1:0] == 2'b00
      |-> pslverr_out == (paddr_in > OFS_STATUS)) else $error("error flag wrong");
   a_err_ready: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside answer");
   a_restart_pulse: assert property (elem_timer_restart_out |=> !elem_timer_restart_out)
      else $error("restart pulse too long");
   a_restart_cause: assert property (elem_timer_restart_out
      |-> $past(dynamic_select_out) && $past(pickup_any_in)) else $error("restart uncaused");
   a_block_normal: assert property (pins_in.block_dynamic [*5] |-> !dynamic_select_out)
      else $error("dynamic while blocked");
   c_dyn: cover property ($rose(dynamic_select_out));
   c_restart: cover property (elem_timer_restart_out);
   c_err: cover property (pslverr_out);
endmodule : dts_checker

/* testbench/dts_partner.sv */
// Far side model: breaker auxiliary contact, current levels and element states.
`timescale 1ns/100ps
module dts_partner (
   input wire logic clk_sys_in,
   input wire logic close_cmd_in,
   input wire logic fault_in,
   input wire logic [1:0] lag_in,
   input wire logic [2:0] elem_in,
   output logic breaker_closed_out,
   output logic current_below_min_out,
   output logic current_above_closed_out,
   output logic [7:0] dropout_cond_out,
   output logic pickup_any_out
);
   logic [3:0] hist_q;
   // The contact lags the command by one to four cycles, like a slow mechanism.
   always_ff @(posedge clk_sys_in) hist_q <= {hist_q[2:0], close_cmd_in};
   assign breaker_closed_out = hist_q[lag_in];
   assign current_below_min_out = !breaker_closed_out;
   assign current_above_closed_out = breaker_closed_out;
   // Only the element chosen by elem_in reports dropout, so one input of the OR is exercised at a time.
   assign dropout_cond_out = (breaker_closed_out && !fault_in) ? 8'h01 << elem_in : 8'h00;
   assign pickup_any_out = fault_in;
endmodule : dts_partner

/* testbench/dts_switchover_tb.sv */
// Self-checking bench for the switchover block.
`timescale 1ns/100ps
module dts_switchover_tb;
   import dts_pkg::*;
   logic clk_sys_in, nrst_in, psel, penable, pwrite, pready, pslverr, sel, rsto, e;
   logic act, blk, bst, rcl, cls, flt, brk, blw, abv, pku;
   logic [1:0] lag;
   logic [2:0] elem;
   logic [7:0] paddr, drop;
   logic [31:0] pwdata, prdata, r, d;
   logic [7:0] offs[4] = '{OFS_CTRL, OFS_WAIT, OFS_HOLD, OFS_FAST};
   logic [31:0] exps[4] = '{32'h0, {16'h0, WAIT_RST}, {16'h0, HOLD_RST}, {16'h0, FAST_RST}};
   dts_pins_t pins;
   int fail_count, n_tests, n_rst;
   assign pins = {brk, act, blk, bst};
   dts_switchover #(.TICK_DIV(4)) uut (.clk_sys_in, .nrst_in, .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pins_in(pins),
      .reclose_ready_in(rcl), .current_below_min_in(blw), .current_above_closed_in(abv),
      .dropout_cond_in(drop), .pickup_any_in(pku), .dynamic_select_out(sel),
      .elem_timer_restart_out(rsto));
   dts_partner fs (.clk_sys_in, .close_cmd_in(cls), .fault_in(flt), .lag_in(lag),
      .elem_in(elem), .breaker_closed_out(brk), .current_below_min_out(blw),
      .current_above_closed_out(abv), .dropout_cond_out(drop), .pickup_any_out(pku));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dw;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      // No wait count is assumed; only the watchdog ends a hung transfer.
      do begin
         @(posedge clk_sys_in);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // An idle cycle keeps a following call from driving psel twice in one step.
      @(posedge clk_sys_in);
   endtask : apb
   // Timers go first so the on bit never runs with stale durations.
   task automatic cfg(input logic [3:0] c, input logic [15:0] w, h, f);
      apb(1'b1, OFS_WAIT, {16'h0, w});
      apb(1'b1, OFS_HOLD, {16'h0, h});
      apb(1'b1, OFS_FAST, {16'h0, f});
      apb(1'b1, OFS_CTRL, {28'h0, c});
   endtask : cfg
   task automatic wsel(input logic v, input int lo, input int hi);
      int n;
      for (n = 0; n < hi && sel !== v; n++) @(posedge clk_sys_in);
      chk(32'(n >= lo && n < hi), 32'h1, "select timing");
   endtask : wsel
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   always @(posedge clk_sys_in) if (rsto === 1'b1) n_rst++;
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      {nrst_in, psel, penable, pwrite, paddr, pwdata} = '0;
      {act, blk, bst, rcl, flt, lag, elem, fail_count, n_tests, n_rst} = '0;
      cls = 1'b1;
      void'($urandom(32'h123bc2ca));
      repeat (20) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 32'h0);
         chk(r, exps[i], "reset value");
         d = $urandom;
         if (i > 0) apb(1'b1, offs[i], d);
         if (i > 0) apb(1'b0, offs[i], 32'h0);
         if (i > 0) chk(r, {16'h0, d[15:0]}, "readback");
      end
      apb(1'b1, OFS_CTRL, 32'h6);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, 32'h0, "unused source code ignored");
      apb(1'b1, 8'h14, 32'hFFFFFFFF);
      chk(32'(e), 32'h1, "unmapped write");
      apb(1'b0, 8'h14, 32'h0);
      chk(32'(e), 32'h1, "unmapped read error");
      chk(r, 32'h0, "unmapped read data");
      $display("test registers done");
      lag <= 2'($urandom);
      elem <= 3'($urandom);
      cfg(4'hB, 16'h3, 16'h5, 16'h1);
      cls <= 1'b0;
      wsel(1'b1, 8, 40);
      cls <= 1'b1;
      wsel(1'b0, 14, 40);
      $display("test aux contact done");
      cfg(4'h1, 16'h2, 16'h00C8, 16'h2);
      cls <= 1'b0;
      wsel(1'b1, 4, 40);
      cls <= 1'b1;
      wsel(1'b0, 6, 40);
      bst <= 1'b1;
      cls <= 1'b0;
      wsel(1'b1, 4, 40);
      cls <= 1'b1;
      repeat (40) @(posedge clk_sys_in);
      chk(32'(sel), 32'h1, "fast reset stopped");
      bst <= 1'b0;
      wsel(1'b0, 4, 40);
      cfg(4'h1, 16'h2, 16'h3, 16'h00C8);
      cls <= 1'b0;
      wsel(1'b1, 4, 40);
      flt <= 1'b1;
      cls <= 1'b1;
      repeat (40) @(posedge clk_sys_in);
      chk(32'(sel), 32'h1, "held by pickup");
      flt <= 1'b0;
      wsel(1'b0, 0, 8);
      $display("test zero current done");
      cfg(4'h5, 16'h3, 16'h3, 16'h3);
      rcl <= 1'b1;
      wsel(1'b1, 0, 4);
      rcl <= 1'b0;
      wsel(1'b0, 0, 3);
      for (int s = 0; s < 3; s++) begin
         cfg({1'b0, 2'(s), 1'b1}, 16'h3, 16'h3, 16'h3);
         act <= 1'b1;
         wsel(1'b1, 0, 6);
         act <= 1'b0;
         wsel(1'b0, 0, 6);
      end
      $display("test forced causes done");
      cfg(4'h3, 16'h1, 16'h2, 16'h1);
      cls <= 1'b0;
      flt <= 1'b1;
      wsel(1'b1, 0, 30);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(r, (32'h1 << ST_DYN_BIT) | (32'(ST_DYN_OPEN) << ST_STATE_LSB), "status");
      n_rst = 0;
      blk <= 1'b1;
      wsel(1'b0, 0, 6);
      repeat (2) @(posedge clk_sys_in);
      chk(n_rst, 32'h1, "restart pulses");
      blk <= 1'b0;
      wsel(1'b1, 2, 30);
      flt <= 1'b0;
      cls <= 1'b1;
      wsel(1'b0, 0, 40);
      $display("test block done");
      cfg(4'h2, 16'h0, 16'h1, 16'h1);
      cls <= 1'b0;
      act <= 1'b1;
      repeat (20) @(posedge clk_sys_in);
      chk(32'(sel), 32'h0, "function off");
      act <= 1'b0;
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      chk(32'(sel), 32'h0, "select after reset");
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, 32'h0, "control after reset");
      cfg(4'h3, 16'h5, 16'h2, 16'h1);
      cls <= 1'b1;
      repeat (40) @(posedge clk_sys_in);
      chk(32'(sel), 32'h0, "normal after power-up close");
      $display("test power-up done");
      final_report();
   end
endmodule : dts_switchover_tb
bind dts_switchover dts_checker u_chk (.clk_sys_in, .nrst_in, .psel_in, .penable_in,
   .paddr_in, .prdata_out, .pready_out, .pslverr_out, .pins_in, .pickup_any_in,
   .dynamic_select_out, .elem_timer_restart_out);
